// ===== rtl/sbcreg_regs.svh
// Register offsets, field positions, reset values and timing counts of the mode/supply bank.
// Assumes inclusion by bare name from the package; both ends use its macros without including it.
`ifndef SBCREG_REGS_SVH
`define SBCREG_REGS_SVH
`define SBCREG_ADDR_MODE_SUPPLY 7'h01
`define SBCREG_ADDR_HARDWARE_CONTROL 7'h02
`define SBCREG_RST_MODE_SUPPLY 8'h00
`define SBCREG_RST_HARDWARE_CONTROL 8'h00
`define SBCREG_WMASK_MODE_SUPPLY 8'hdf
`define SBCREG_WMASK_HARDWARE_CONTROL 8'h61
`define SBCREG_RS_KEEP_MODE_SUPPLY 8'h03
`define SBCREG_RS_KEEP_HARDWARE_CONTROL 8'h41
`define SBCREG_MODE_HI 7
`define SBCREG_MODE_LO 6
`define SBCREG_REG2_HI 4
`define SBCREG_REG2_LO 3
`define SBCREG_OV_BIT 2
`define SBCREG_RT_HI 1
`define SBCREG_RT_LO 0
`define SBCREG_SRO_BIT 6
`define SBCREG_FO_BIT 5
`define SBCREG_CFG_BIT 0
`define SBCREG_WRITE_BIT 7
`define SBCREG_FRAME_BITS 16
`define SBCREG_SCK_HALF 2
`define SBCREG_SOFTRST_CYCLES 4
`endif

// ===== rtl/sbcreg_pkg.sv
// Types shared by the host end, the device end and the bench.
// Assumes the constants header is on the include path.
package sbcreg_pkg;
  `include "sbcreg_regs.svh"
  typedef enum logic [1:0] {
    SBCREG_NORMAL = 2'h0,
    SBCREG_SLEEP = 2'h1,
    SBCREG_STOP = 2'h2,
    SBCREG_SOFTRST = 2'h3
  } sbcreg_mode_e;
  typedef logic [7:0] sbcreg_byte_t;
  typedef logic [6:0] sbcreg_addr_t;
endpackage

// ===== rtl/sbcreg_if.sv
// SPI link between the microcontroller end and the register bank end.
// Assumes one shared clock; serial clock is a sampled level, not a clock domain.
`timescale 1ns/10ps
interface sbcreg_if;
  logic csn;
  logic sck;
  logic mosi;
  logic miso;
  modport host (output csn, output sck, output mosi, input miso);
  modport device (input csn, input sck, input mosi, output miso);
endinterface

// ===== rtl/sbcreg_shift.sv
// Sixteen-bit serial shifter, LSB first, shared by both ends.
// Assumes sck edges are reported as one-cycle pulses by the owner.
`timescale 1ns/10ps
module sbcreg_shift #(
  parameter int WIDTH = 16
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] load_data_i,
  input wire logic shift_i,
  input wire logic serial_i,
  output logic serial_o,
  output logic [WIDTH-1:0] data_o
);
  typedef struct packed {
    logic [WIDTH-1:0] sh;
  } sbcreg_shift_s;
  sbcreg_shift_s st, next_st;

  ////////////////////////////////////////////////////////////////////
  // Load wins over shift; data enters at the top so bit 0 leaves first
  always_comb begin
    next_st = st;
    if (load_i) begin
      next_st.sh = load_data_i;
    end else if (shift_i) begin
      next_st.sh = {serial_i, st.sh[WIDTH-1:1]};
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign serial_o = st.sh[0];
  assign data_o = st.sh;
endmodule

// ===== rtl/sbcreg_device.sv
// Device end: SPI slave holding the mode/supply and hardware control registers.
// Assumes sck, csn and mosi are synchronous to ref_clk_i and sck is slow (>=2 clk per half).
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
// Operation
// - Frame is address/mode byte then data
// - Bit 7 low reads without change
// - Bit 7 high stores data byte
// - Data bits map to frame bits 8-15
// - Reserved bits read zero, written zero
// - Reset and restart load defined values
// - Only hardware-typed bits change by hardware
// - Mode field encodes normal/sleep/stop/softreset
// - Soft reset drives reset pin unless suppressed
// - Secondary regulator four-way mode select
// - Overvoltage sets flag, optionally restarts
// - Reset threshold select, four levels
// - No stop to sleep via write
// - Restart forces mode to normal
// - Restart or overtemp turns regulator off
// - Write returns previous register content
// - Software bit activates failure outputs
// - Config bit selects watchdog failure reaction
// - Failure latch survives software clear
module sbcreg_device (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  sbcreg_if.device link,
  input wire logic restart_i,
  input wire logic overtemp_i,
  input wire logic overvoltage_i,
  input wire logic failure_event_i,
  input wire logic failure_clear_i,
  input wire logic wd_fail_second_i,
  output sbcreg_pkg::sbcreg_mode_e chip_mode_o,
  output logic [1:0] secondary_regulator_mode_o,
  output logic [1:0] reset_threshold_select_o,
  output logic primary_supply_overvoltage_flag_o,
  output logic restart_request_o,
  output logic reset_output_pin_n_o,
  output logic failure_output_pins_o,
  output logic cfg_select_o
);
  import sbcreg_pkg::*;

  typedef struct packed {
    sbcreg_byte_t mode_supply;
    sbcreg_byte_t hardware_control;
    logic sck_q;
    logic [4:0] cnt;
    logic ov_flag;
    logic fail_latch;
    logic restart_req;
    logic [3:0] softrst_cnt;
    logic softrst_pin;
    logic miso_q;
  } sbcreg_dev_s;
  sbcreg_dev_s st, next_st;

  logic rise, fall, load, shift_out;
  logic [15:0] frame;
  sbcreg_addr_t addr;
  sbcreg_addr_t rd_addr;
  sbcreg_byte_t rd_byte;

  // Register read mux, reserved bits forced to zero
  function automatic sbcreg_byte_t sbcreg_read(input sbcreg_addr_t a, input sbcreg_byte_t ms,
                                               input sbcreg_byte_t hw);
    case (a)
      `SBCREG_ADDR_MODE_SUPPLY: sbcreg_read = ms & `SBCREG_WMASK_MODE_SUPPLY;
      `SBCREG_ADDR_HARDWARE_CONTROL: sbcreg_read = hw & `SBCREG_WMASK_HARDWARE_CONTROL;
      default: sbcreg_read = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Edge detection of the sampled serial clock
  assign rise = link.sck && !st.sck_q && !link.csn;
  assign fall = !link.sck && st.sck_q && !link.csn;
  assign addr = frame[6:0];
  // After eight bits the first byte sits in the upper half of the shifter
  assign rd_addr = frame[14:8];
  assign rd_byte = sbcreg_read(rd_addr, st.mode_supply, st.hardware_control);
  // Reply byte loaded once the first byte is in, before data bits leave
  assign load = fall && (st.cnt == 5'd8);

  sbcreg_shift #(
    .WIDTH(16)
  ) u_shift (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .load_i(load),
    .load_data_i({frame[15:8], rd_byte}),
    .shift_i(rise),
    .serial_i(link.mosi),
    .serial_o(shift_out),
    .data_o(frame)
  );

  ////////////////////////////////////////////////////////////////////
  // Frame handling, register updates and hardware events
  always_comb begin
    next_st = st;
    next_st.sck_q = link.sck;
    if (link.csn) begin
      next_st.cnt = '0;
    end else if (rise) begin
      next_st.cnt = st.cnt + 5'd1;
    end
    // Reply bit changes only on falling sck or deselect so it stands through the high phase
    if (link.csn) begin
      next_st.miso_q = 1'b0;
    end else if (load) begin
      next_st.miso_q = rd_byte[0];
    end else if (fall) begin
      next_st.miso_q = (st.cnt > 5'd8) ? shift_out : 1'b0;
    end
    next_st.restart_req = 1'b0;
    // Frame end: commit write only for complete 16-bit frames
    if (link.csn && st.cnt == 5'd16 && frame[`SBCREG_WRITE_BIT]) begin
      case (addr)
        `SBCREG_ADDR_MODE_SUPPLY: begin
          next_st.mode_supply = (st.mode_supply & ~`SBCREG_WMASK_MODE_SUPPLY)
            | (frame[15:8] & `SBCREG_WMASK_MODE_SUPPLY);
          if (st.mode_supply[7:6] == SBCREG_STOP && frame[15:14] == SBCREG_SLEEP) begin
            next_st.mode_supply[7:6] = SBCREG_STOP;
          end
          if (frame[15:14] == SBCREG_SOFTRST) begin
            next_st.softrst_cnt = 4'(`SBCREG_SOFTRST_CYCLES);
            next_st.softrst_pin = !st.hardware_control[`SBCREG_SRO_BIT];
          end
        end
        `SBCREG_ADDR_HARDWARE_CONTROL: begin
          next_st.hardware_control = (st.hardware_control & ~`SBCREG_WMASK_HARDWARE_CONTROL)
            | (frame[15:8] & `SBCREG_WMASK_HARDWARE_CONTROL);
        end
        default: ;
      endcase
    end
    // Soft reset: registers go to reset values while the soft reset count runs, pin held or not
    if (st.softrst_cnt != 4'h0) begin
      next_st.softrst_cnt = st.softrst_cnt - 4'd1;
      next_st.mode_supply = `SBCREG_RST_MODE_SUPPLY;
      next_st.hardware_control = `SBCREG_RST_HARDWARE_CONTROL;
      if (st.softrst_cnt == 4'd1) begin
        next_st.softrst_pin = 1'b0;
      end
    end
    // Overvoltage flag, set and held until reset; restart only when enabled
    if (overvoltage_i) begin
      next_st.ov_flag = 1'b1;
      next_st.restart_req = st.mode_supply[`SBCREG_OV_BIT];
    end
    // Second watchdog failure with config 0 asks for restart/fail-safe
    if (wd_fail_second_i && !st.hardware_control[`SBCREG_CFG_BIT]) begin
      next_st.restart_req = 1'b1;
    end
    if (failure_clear_i) begin
      next_st.fail_latch = 1'b0;
    end
    if (failure_event_i) begin
      next_st.fail_latch = 1'b1;
    end
    if (overtemp_i) begin
      next_st.mode_supply[4:3] = 2'h0;
    end
    // Restart values: x positions keep content
    if (restart_i) begin
      next_st.mode_supply = st.mode_supply & `SBCREG_RS_KEEP_MODE_SUPPLY;
      next_st.hardware_control = st.hardware_control & `SBCREG_RS_KEEP_HARDWARE_CONTROL;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs; reply only drives once the address byte is in
  assign link.miso = st.miso_q;
  assign chip_mode_o = sbcreg_mode_e'(st.mode_supply[7:6]);
  assign secondary_regulator_mode_o = st.mode_supply[4:3];
  assign reset_threshold_select_o = st.mode_supply[1:0];
  assign primary_supply_overvoltage_flag_o = st.ov_flag;
  assign restart_request_o = st.restart_req;
  assign reset_output_pin_n_o = !st.softrst_pin;
  assign failure_output_pins_o = st.hardware_control[`SBCREG_FO_BIT] | st.fail_latch;
  assign cfg_select_o = st.hardware_control[`SBCREG_CFG_BIT];
endmodule

// ===== rtl/sbcreg_host.sv
// Host end: turns software register commands into 16-bit SPI frames.
// Assumes software port: one-cycle strobes, read data one cycle later.
`timescale 1ns/10ps
module sbcreg_host (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  sbcreg_if.host link,
  input wire logic [1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o
);
  import sbcreg_pkg::*;
  // Port offsets: 0 command (write starts frame), 1 reply, 2 status
  localparam logic [1:0] SBCREG_HOST_CMD = 2'h0;
  localparam logic [1:0] SBCREG_HOST_REPLY = 2'h1;
  localparam logic [1:0] SBCREG_HOST_STAT = 2'h2;

  typedef enum logic [1:0] {SBCREG_IDLE, SBCREG_LOW, SBCREG_HIGH, SBCREG_END} sbcreg_host_e;
  typedef struct packed {
    sbcreg_host_e fsm;
    logic [3:0] div;
    logic [4:0] bits;
    logic csn;
    logic sck;
    logic [15:0] reply;
    logic [15:0] rdata;
  } sbcreg_host_s;
  sbcreg_host_s st, next_st;
  logic load, shift_rx, mosi_bit;
  logic [15:0] sh;

  // Reserved data bits of known registers go out as zero; others pass untouched
  function automatic logic [15:0] sbcreg_host_mask(input logic [15:0] d);
    logic [7:0] m;
    case (d[6:0])
      `SBCREG_ADDR_MODE_SUPPLY: m = `SBCREG_WMASK_MODE_SUPPLY;
      `SBCREG_ADDR_HARDWARE_CONTROL: m = `SBCREG_WMASK_HARDWARE_CONTROL;
      default: m = 8'hff;
    endcase
    sbcreg_host_mask = {d[15:8] & m, d[7:0]};
  endfunction

  sbcreg_shift #(
    .WIDTH(16)
  ) u_shift (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .load_i(load),
    .load_data_i(sbcreg_host_mask(wdata_i)),
    .shift_i(shift_rx),
    .serial_i(link.miso),
    .serial_o(mosi_bit),
    .data_o(sh)
  );

  // Command write starts a frame when idle; busy writes are ignored
  assign load = wr_i && addr_i == SBCREG_HOST_CMD && st.fsm == SBCREG_IDLE;
  assign shift_rx = st.fsm == SBCREG_HIGH && st.div == 4'd0;

  ////////////////////////////////////////////////////////////////////
  // Serial clock generator, mode 0, LSB first
  always_comb begin
    next_st = st;
    next_st.rdata = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        SBCREG_HOST_REPLY: next_st.rdata = st.reply;
        SBCREG_HOST_STAT: next_st.rdata = {15'h0000, st.fsm != SBCREG_IDLE};
        default: next_st.rdata = 16'h0000;
      endcase
    end
    case (st.fsm)
      SBCREG_IDLE: begin
        if (load) begin
          next_st.csn = 1'b0;
          next_st.bits = '0;
          next_st.div = 4'(`SBCREG_SCK_HALF);
          next_st.fsm = SBCREG_LOW;
        end
      end
      SBCREG_LOW: begin
        next_st.div = st.div - 4'd1;
        if (st.div == 4'd0) begin
          next_st.sck = 1'b1;
          next_st.div = 4'(`SBCREG_SCK_HALF);
          next_st.fsm = SBCREG_HIGH;
        end
      end
      SBCREG_HIGH: begin
        next_st.div = st.div - 4'd1;
        if (st.div == 4'd0) begin
          next_st.sck = 1'b0;
          next_st.div = 4'(`SBCREG_SCK_HALF);
          next_st.bits = st.bits + 5'd1;
          next_st.fsm = (st.bits == 5'd15) ? SBCREG_END : SBCREG_LOW;
        end
      end
      SBCREG_END: begin
        next_st.div = st.div - 4'd1;
        if (st.div == 4'd0) begin
          next_st.csn = 1'b1;
          next_st.reply = sh;
          next_st.fsm = SBCREG_IDLE;
        end
      end
      default: next_st.fsm = SBCREG_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '{fsm: SBCREG_IDLE, csn: 1'b1, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign link.csn = st.csn;
  assign link.sck = st.sck;
  assign link.mosi = mosi_bit;
  assign rdata_o = st.rdata;
endmodule

// ===== tb/sbcreg_asserts.sv
// Link checker: framing and timing of the serial wire between both ends.
// Assumes one clock; the bench instantiates it beside the link.
`timescale 1ns/10ps
module sbcreg_asserts (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic csn,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  logic [4:0] nbit;
  logic sck_q;
  ////////////////////////////////////////
  // Count clock rises per frame; a short frame would be dropped silently
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nbit <= 5'h0;
      sck_q <= 1'b0;
    end else begin
      sck_q <= sck;
      if (csn) begin
        nbit <= 5'h0;
      end else if (sck && !sck_q) begin
        nbit <= nbit + 5'h1;
      end
    end
  end
  ////////////////////////////////////////
  a_sck_idle_low: assert property (csn |-> !sck)
    else $error("serial clock active while deselected");
  a_frame_bit_count: assert property ($rose(csn) |-> nbit == 5'h10)
    else $error("frame not sixteen bits");
  a_frame_length: assert property ($fell(csn) |-> ##[96:110] $rose(csn))
    else $error("frame length out of range");
  a_select_lead: assert property ($fell(csn) |-> !sck [*3])
    else $error("clock rose too soon after select");
  a_sck_high_len: assert property ($rose(sck) |-> sck [*3])
    else $error("clock high phase too short");
  a_sck_low_len: assert property ($fell(sck) && !csn |-> !sck [*3])
    else $error("clock low phase too short");
  a_mosi_hold: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("host data moved while clock high");
  a_miso_hold: assert property (sck && $past(sck) |-> $stable(miso))
    else $error("device data moved while clock high");
endmodule

// ===== tb/tb_sbc_spi_mode_supply_control_regs.sv
// Bench: host end drives the device end over the link; software port tasks.
// Assumes the rtl package, header and interface are compiled first.
`timescale 1ns/10ps
module tb_sbc_spi_mode_supply_control_regs;
  import sbcreg_pkg::*;
  logic ref_clk_i, rstn_i, wr_i, rd_i;
  logic [1:0] addr_i, reg2, rt;
  logic [15:0] wdata_i, rdata_o;
  logic [5:0] ev;
  sbcreg_mode_e mode;
  logic ovf, req, pin_n, fo, cfg, low_seen;
  logic [7:0] r;
  int num_errors = 0;
  int n_compared = 0;
  int n_req = 0;
  sbcreg_if link ();
  sbcreg_host u_sbcreg_host (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .link(link),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
  sbcreg_device u_sbcreg_device (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .link(link),
    .restart_i(ev[0]), .overtemp_i(ev[1]), .overvoltage_i(ev[2]),
    .failure_event_i(ev[3]), .failure_clear_i(ev[4]), .wd_fail_second_i(ev[5]),
    .chip_mode_o(mode), .secondary_regulator_mode_o(reg2), .reset_threshold_select_o(rt),
    .primary_supply_overvoltage_flag_o(ovf), .restart_request_o(req),
    .reset_output_pin_n_o(pin_n), .failure_output_pins_o(fo), .cfg_select_o(cfg));
  sbcreg_asserts u_sbcreg_asserts (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .csn(link.csn), .sck(link.sck), .mosi(link.mosi), .miso(link.miso));
  ////////////////////////////////////////
  // Free-running clock
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  // Pulses are one to four cycles, so they are counted here rather than polled
  always @(posedge ref_clk_i) begin
    if (req === 1'b1) n_req++;
    if (pin_n === 1'b0) low_seen = 1'b1;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // One software cycle; read data taken in the cycle after the strobe
  task automatic sw(input logic [1:0] a, input logic [15:0] d, input logic w,
                    output logic [15:0] q);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= w;
    rd_i <= !w;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1 q = rdata_o;
  endtask
  // Whole frame: start, poll busy under a bound, fetch reply byte into r
  task automatic frame(input logic [6:0] a, input logic w, input logic [7:0] d);
    logic [15:0] q;
    int i;
    sw(2'h0, {d, w, a}, 1'b1, q);
    repeat (3) @(posedge ref_clk_i);
    for (i = 0; i < 300; i++) begin
      sw(2'h2, 16'h0, 1'b0, q);
      if (q[0] === 1'b0) break;
    end
    chk("busy", 16'h0, {15'h0, q[0]});
    sw(2'h1, 16'h0, 1'b0, q);
    r = q[15:8];
  endtask
  task automatic pulse(input int k);
    @(posedge ref_clk_i);
    ev[k] <= 1'b1;
    @(posedge ref_clk_i);
    ev[k] <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1;
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    frame(7'h01, 1'b0, 8'h00);
    chk("ms_rst", 16'h0, r);
    frame(7'h02, 1'b0, 8'h00);
    chk("hw_rst", 16'h0, r);
    chk("pin_rst", 16'h1, pin_n);
  endtask
  task automatic t_rw();
    frame(7'h01, 1'b1, 8'h1b);
    chk("reg2", 16'h3, reg2);
    chk("rt", 16'h3, rt);
    chk("mode", 16'h0, mode);
    frame(7'h01, 1'b1, 8'h0a);
    chk("ms_old", 16'h1b, r);
    chk("rt2", 16'h2, rt);
    frame(7'h01, 1'b0, 8'hff);
    chk("ms_rd", 16'h0a, r);
  endtask
  task automatic t_hw();
    frame(7'h02, 1'b1, 8'hff);
    frame(7'h02, 1'b0, 8'h00);
    chk("hw_mask", 16'h61, r);
    chk("fo_sw", 16'h1, fo);
    chk("cfg", 16'h1, cfg);
  endtask
  task automatic t_modes();
    frame(7'h01, 1'b1, 8'h4a);
    chk("sleep", 16'h1, mode);
    frame(7'h01, 1'b1, 8'h0a);
    frame(7'h01, 1'b1, 8'h8a);
    chk("stop", 16'h2, mode);
    frame(7'h01, 1'b1, 8'h4a);
    chk("stop_sleep", 16'h2, mode);
  endtask
  task automatic t_restart();
    pulse(0);
    chk("rs_mode", 16'h0, mode);
    chk("rs_reg2", 16'h0, reg2);
    chk("rs_rt", 16'h2, rt);
    frame(7'h02, 1'b0, 8'h00);
    chk("rs_hw", 16'h41, r);
    chk("rs_fo", 16'h0, fo);
  endtask
  task automatic t_ovt();
    frame(7'h01, 1'b1, 8'h18);
    chk("ot_on", 16'h3, reg2);
    pulse(1);
    chk("ot_off", 16'h0, reg2);
  endtask
  task automatic t_req();
    n_req = 0;
    pulse(2);
    chk("ov_flag", 16'h1, ovf);
    chk("ov_noreq", 16'h0, 16'(n_req));
    frame(7'h01, 1'b1, 8'h04);
    n_req = 0;
    pulse(2);
    chk("ov_req", 16'h1, {15'h0, n_req != 0});
    n_req = 0;
    pulse(5);
    chk("wd_noreq", 16'h0, 16'(n_req));
    frame(7'h02, 1'b1, 8'h00);
    n_req = 0;
    pulse(5);
    chk("wd_req", 16'h1, {15'h0, n_req != 0});
  endtask
  task automatic t_fail();
    frame(7'h02, 1'b1, 8'h20);
    pulse(3);
    frame(7'h02, 1'b1, 8'h00);
    chk("fo_latch", 16'h1, fo);
    pulse(4);
    chk("fo_clear", 16'h0, fo);
  endtask
  // Soft reset with and without the reset pin suppressed
  task automatic t_soft();
    low_seen = 1'b0;
    frame(7'h01, 1'b1, 8'hc0);
    repeat (10) @(posedge ref_clk_i);
    chk("sr_pin", 16'h1, low_seen);
    frame(7'h01, 1'b0, 8'h00);
    chk("sr_ms", 16'h0, r);
    frame(7'h02, 1'b1, 8'h40);
    low_seen = 1'b0;
    frame(7'h01, 1'b1, 8'hc0);
    repeat (10) @(posedge ref_clk_i);
    chk("sr_quiet", 16'h0, low_seen);
    frame(7'h02, 1'b0, 8'h00);
    chk("sr_hw", 16'h0, r);
  endtask
  task automatic test_done();
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // Watchdog well beyond the roughly 2500 cycles the tests take
  initial begin
    #3000000;
    num_errors++;
    test_done();
  end
  initial begin
    rstn_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 2'h0;
    wdata_i = 16'h0;
    ev = 6'h0;
    repeat (8) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_rw();
    t_hw();
    t_modes();
    t_restart();
    t_ovt();
    t_req();
    t_fail();
    t_soft();
    test_done();
  end
endmodule
